// ### gpio_pkg.sv
// Shared constants and carrier types for the three-port general-purpose I/O block.
package gpio_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [5:0] IDX_ANALOG_DATA = 6'h01;
   localparam logic [5:0] IDX_CLOCK_DATA = 6'h02;
   localparam logic [5:0] IDX_PULLUP_DATA = 6'h03;
   localparam logic [5:0] IDX_ANALOG_DIR = 6'h05;
   localparam logic [5:0] IDX_CLOCK_DIR = 6'h06;
   localparam logic [5:0] IDX_PULLUP_DIR = 6'h07;
   localparam logic [5:0] IDX_PULLUP_EN = 6'h0E;
   // Field positions.
   localparam int CLK_PIN_BIT = 2;
   localparam int CLK_EN_BIT = 7;
   localparam int TA_PIN_BIT = 6;
   localparam int TB_PIN_BIT = 4;
   // Reset values of the control fields.
   localparam logic [7:0] DIR8_RST = 8'h00;
   localparam logic [5:0] DIR6_RST = 6'h00;
   localparam logic CLK_EN_RST = 1'b0;
   localparam logic [7:0] PUE_RST = 8'h00;
   // Prescaler code that hands a pin to a timer as its external clock.
   localparam logic [2:0] PS_EXT_CLK = 3'h7;
   // Number of converter channels that sit on the analog-shared port.
   localparam logic [4:0] ANA_CHANNELS = 5'h08;

   // One APB request as seen by the slave.
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   // Pin group: output level and output enable.
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pin8_t;
endpackage

// ### gpio_ports_b_c_d.sv
// Register file and pin logic for the analog-shared, clock-output and pullup ports.
//
// Behaviour
// - Analog port data latch, eight bits, reset-proof.
// - Selected converter channel pin becomes analog input.
// - Unselected analog port pins are plain digital I/O.
// - Direction 1 drives pin; reset makes inputs.
// - Data writes always load latch, input unaffected.
// - Clock port data latch, six bits, reset-proof.
// - Enable bit puts system clock on bit 2.
// - Six clock port direction bits, reset to input.
// - Pullup port data latch, eight bits, reset-proof.
// - Per-pin switchable pullups and strong sink drive.
// - Pullup disabled while pin is an output.
// - Pins 6 and 4 feed timer external clocks.
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module gpio_ports_b_c_d (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog-shared port pins and converter link
   input wire logic [7:0] analog_pin_in,
   output gpio_pkg::pin8_t analog_pin,
   input wire logic [4:0] conv_channel_select,
   output logic [7:0] converter_input_pins,
   // Clock-output port pins
   input wire logic [5:0] clock_pin_in,
   output logic [5:0] clock_pin_out,
   output logic [5:0] clock_pin_oe,
   // Pullup-capable port pins
   input wire logic [7:0] pullup_pin_in,
   output gpio_pkg::pin8_t pullup_pin,
   output logic [7:0] pullup_on,
   output logic [7:0] strong_sink_on,
   // Timer clock links
   input wire logic [2:0] timer_a_prescaler_select,
   input wire logic [2:0] timer_b_prescaler_select,
   output logic timer_a_ext_clock,
   output logic timer_b_ext_clock
);

   // Whole state of the block.
   typedef struct packed {
      logic [7:0] a_dat;
      logic [5:0] c_dat;
      logic [7:0] d_dat;
      logic [7:0] a_dir;
      logic [5:0] c_dir;
      logic clk_en;
      logic [7:0] d_dir;
      logic [7:0] d_pue;
      logic [31:0] rdata;
      logic err;
   } state_t;

   state_t st_ff;
   state_t nxt_st;
   gpio_pkg::apb_req_t req;
   logic [5:0] idx;
   logic mapped;
   logic setup_ph;
   logic wr_acc;
   logic [7:0] ana_sel;
   logic [7:0] c_mix;

   // Per bit, outputs read back their latch and inputs read the pin.
   function automatic logic [7:0] rd_mix(input logic [7:0] lat, input logic [7:0] dir,
                                         input logic [7:0] pin);
      rd_mix = (lat & dir) | (pin & ~dir);
   endfunction

   // Bus decode; the slave never stalls, so pready stays high.
   assign req = '{psel, penable, pwrite, paddr, pwdata};
   assign idx = req.paddr[7:2];
   assign setup_ph = req.psel & ~req.penable;
   assign wr_acc = req.psel & req.penable & req.pwrite & mapped;
   assign pready = 1'b1;
   assign prdata = st_ff.rdata;
   assign pslverr = st_ff.err;

   // Word-aligned addresses that hit a register.
   always_comb begin
      mapped = 1'b0;
      if (req.paddr[1:0] == 2'h0) begin
         case (idx)
            gpio_pkg::IDX_ANALOG_DATA, gpio_pkg::IDX_CLOCK_DATA,
            gpio_pkg::IDX_PULLUP_DATA, gpio_pkg::IDX_ANALOG_DIR,
            gpio_pkg::IDX_CLOCK_DIR, gpio_pkg::IDX_PULLUP_DIR,
            gpio_pkg::IDX_PULLUP_EN: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   end

   // One-hot pick of the analog channel; codes past the port select no pin.
   always_comb begin
      ana_sel = 8'h00;
      if (conv_channel_select < gpio_pkg::ANA_CHANNELS) begin
         ana_sel[conv_channel_select[2:0]] = 1'b1;
      end
   end

   // Clock port pins widened to the byte that the read mix works on.
   assign c_mix = rd_mix({2'h0, st_ff.c_dat}, {2'h0, st_ff.c_dir},
                         {2'h0, clock_pin_in});

   // Next state: writes land at the access edge, read data is caught at setup.
   always_comb begin
      nxt_st = st_ff;
      if (wr_acc) begin
         case (idx)
            gpio_pkg::IDX_ANALOG_DATA: nxt_st.a_dat = req.pwdata[7:0];
            gpio_pkg::IDX_CLOCK_DATA: nxt_st.c_dat = req.pwdata[5:0];
            gpio_pkg::IDX_PULLUP_DATA: nxt_st.d_dat = req.pwdata[7:0];
            gpio_pkg::IDX_ANALOG_DIR: nxt_st.a_dir = req.pwdata[7:0];
            gpio_pkg::IDX_CLOCK_DIR: begin
               nxt_st.c_dir = req.pwdata[5:0];
               nxt_st.clk_en = req.pwdata[gpio_pkg::CLK_EN_BIT];
            end
            gpio_pkg::IDX_PULLUP_DIR: nxt_st.d_dir = req.pwdata[7:0];
            gpio_pkg::IDX_PULLUP_EN: nxt_st.d_pue = req.pwdata[7:0];
            default: nxt_st.d_pue = st_ff.d_pue;
         endcase
      end
      if (setup_ph) begin
         nxt_st.err = ~mapped;
         nxt_st.rdata = 32'h0000_0000;
         if (~req.pwrite) begin
            case (idx)
               // Analog-selected pins have their digital input cut, so read as zero.
               gpio_pkg::IDX_ANALOG_DATA: nxt_st.rdata[7:0] =
                  rd_mix(st_ff.a_dat, st_ff.a_dir, analog_pin_in) & ~ana_sel;
               gpio_pkg::IDX_CLOCK_DATA: begin
                  nxt_st.rdata[5:0] = c_mix[5:0];
                  if (st_ff.clk_en) begin
                     nxt_st.rdata[gpio_pkg::CLK_PIN_BIT] = 1'b0;
                  end
               end
               gpio_pkg::IDX_PULLUP_DATA: nxt_st.rdata[7:0] =
                  rd_mix(st_ff.d_dat, st_ff.d_dir, pullup_pin_in);
               gpio_pkg::IDX_ANALOG_DIR: nxt_st.rdata[7:0] = st_ff.a_dir;
               gpio_pkg::IDX_CLOCK_DIR: nxt_st.rdata[7:0] =
                  {st_ff.clk_en, 1'b0, st_ff.c_dir};
               gpio_pkg::IDX_PULLUP_DIR: nxt_st.rdata[7:0] = st_ff.d_dir;
               gpio_pkg::IDX_PULLUP_EN: nxt_st.rdata[7:0] = st_ff.d_pue;
               default: nxt_st.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // Reset clears control, read data and error; the data latches keep whatever they held.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_ff.a_dir <= gpio_pkg::DIR8_RST;
         st_ff.c_dir <= gpio_pkg::DIR6_RST;
         st_ff.clk_en <= gpio_pkg::CLK_EN_RST;
         st_ff.d_dir <= gpio_pkg::DIR8_RST;
         st_ff.d_pue <= gpio_pkg::PUE_RST;
         st_ff.rdata <= 32'h0000_0000;
         st_ff.err <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Analog port drivers; a selected channel forces its pin off the digital path.
   assign analog_pin = '{out: st_ff.a_dat,
                         oe: st_ff.a_dir & ~ana_sel};
   assign converter_input_pins = ana_sel;

   // Clock port drivers; the system clock wins over latch and direction on bit 2.
   // The clock is muxed straight to the pad, so its duty cycle is that of clk_sys.
   always_comb begin
      clock_pin_out = st_ff.c_dat;
      clock_pin_oe = st_ff.c_dir;
      if (st_ff.clk_en) begin
         clock_pin_out[gpio_pkg::CLK_PIN_BIT] = clk_sys;
         clock_pin_oe[gpio_pkg::CLK_PIN_BIT] = 1'b1;
      end
   end

   // Pullup port drivers; a pullup only acts on an input pin.
   assign pullup_pin = '{out: st_ff.d_dat,
                         oe: st_ff.d_dir};
   assign pullup_on = st_ff.d_pue & ~st_ff.d_dir;
   assign strong_sink_on = st_ff.d_dir;

   // Timer external clocks pass the pin level only under the external prescaler code.
   assign timer_a_ext_clock = (timer_a_prescaler_select == gpio_pkg::PS_EXT_CLK) &
                              pullup_pin_in[gpio_pkg::TA_PIN_BIT];
   assign timer_b_ext_clock = (timer_b_prescaler_select == gpio_pkg::PS_EXT_CLK) &
                              pullup_pin_in[gpio_pkg::TB_PIN_BIT];

   // Checks on the register and pin behaviour.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   property p_a_latch;
      wr_acc && idx == gpio_pkg::IDX_ANALOG_DATA |=> st_ff.a_dat == $past(pwdata[7:0]);
   endproperty
   a_a_latch: assert property (p_a_latch) else $error("Analog latch not written.");

   property p_a_oe;
      wr_acc && idx == gpio_pkg::IDX_ANALOG_DIR |=>
         analog_pin.oe == ($past(pwdata[7:0]) & ~ana_sel);
   endproperty
   a_a_oe: assert property (p_a_oe) else $error("Analog driver enable wrong.");

   property p_a_sel;
      (analog_pin.oe & ana_sel) == 8'h00;
   endproperty
   a_a_sel: assert property (p_a_sel) else $error("Selected channel still driven.");

   property p_a_read;
      setup_ph && !pwrite && idx == gpio_pkg::IDX_ANALOG_DATA |=>
         prdata[7:0] == ($past(rd_mix(st_ff.a_dat, st_ff.a_dir, analog_pin_in)) &
                         $past(~ana_sel));
   endproperty
   a_a_read: assert property (p_a_read) else $error("Analog port read wrong.");

   property p_c_latch;
      wr_acc && idx == gpio_pkg::IDX_CLOCK_DATA |=> st_ff.c_dat == $past(pwdata[5:0]);
   endproperty
   a_c_latch: assert property (p_c_latch) else $error("Clock port latch not written.");

   property p_c_en;
      wr_acc && idx == gpio_pkg::IDX_CLOCK_DIR && pwdata[7] |=>
         clock_pin_oe[gpio_pkg::CLK_PIN_BIT] ##1 clock_pin_oe[gpio_pkg::CLK_PIN_BIT];
   endproperty
   a_c_en: assert property (p_c_en) else $error("Clock pin not driven.");

   property p_c_oe;
      !st_ff.clk_en |-> clock_pin_oe == st_ff.c_dir;
   endproperty
   a_c_oe: assert property (p_c_oe) else $error("Clock port enables wrong.");

   property p_pullup;
      wr_acc && idx == gpio_pkg::IDX_PULLUP_DIR |=> (pullup_on & $past(pwdata[7:0])) == 8'h00;
   endproperty
   a_pullup: assert property (p_pullup) else $error("Pullup on an output.");

   property p_d_latch;
      wr_acc && idx == gpio_pkg::IDX_PULLUP_DATA |=> pullup_pin.out == $past(pwdata[7:0]);
   endproperty
   a_d_latch: assert property (p_d_latch) else $error("Pullup latch not written.");

   property p_timer_a;
      timer_a_prescaler_select != gpio_pkg::PS_EXT_CLK |-> !timer_a_ext_clock;
   endproperty
   a_timer_a: assert property (p_timer_a) else $error("Timer clock leaks.");

   property p_timer_b;
      timer_b_prescaler_select != gpio_pkg::PS_EXT_CLK |-> !timer_b_ext_clock;
   endproperty
   a_timer_b: assert property (p_timer_b) else $error("Timer clock leaks.");

   // A clock port read mixes latch and pin by direction when the clock output is off.
   property p_c_read;
      setup_ph && !pwrite && idx == gpio_pkg::IDX_CLOCK_DATA && !st_ff.clk_en |=>
         prdata[5:0] == $past((st_ff.c_dat & st_ff.c_dir) | (clock_pin_in & ~st_ff.c_dir));
   endproperty
   a_c_read: assert property (p_c_read) else $error("Clock port read wrong.");

   // The clock-output bit never shows a latch or pad level while the clock drives it.
   property p_c_bit2;
      setup_ph && !pwrite && idx == gpio_pkg::IDX_CLOCK_DATA && st_ff.clk_en |=>
         !prdata[gpio_pkg::CLK_PIN_BIT];
   endproperty
   a_c_bit2: assert property (p_c_bit2) else $error("Clock bit read not zero.");

   // Inputs read the pad, so a latch write on an input pin cannot show through.
   property p_d_read;
      setup_ph && !pwrite && idx == gpio_pkg::IDX_PULLUP_DATA |=>
         prdata[7:0] == $past((st_ff.d_dat & st_ff.d_dir) | (pullup_pin_in & ~st_ff.d_dir));
   endproperty
   a_d_read: assert property (p_d_read) else $error("Pullup port read wrong.");

   // A pullup enable write takes effect only on the pins that are inputs.
   property p_pue;
      wr_acc && idx == gpio_pkg::IDX_PULLUP_EN |=>
         pullup_on == ($past(pwdata[7:0]) & ~pullup_pin.oe);
   endproperty
   a_pue: assert property (p_pue) else $error("Pullup enable wrong.");

   c_wr_dir: cover property (wr_acc && idx == gpio_pkg::IDX_ANALOG_DIR);
   c_clk_out: cover property (st_ff.clk_en ##1 !st_ff.clk_en);
   c_bad_addr: cover property (setup_ph && !mapped ##1 pslverr);
   c_sel_read: cover property (setup_ph && !pwrite &&
                               idx == gpio_pkg::IDX_ANALOG_DATA && |ana_sel);
   c_timer_clk: cover property (timer_a_ext_clock ##1 !timer_a_ext_clock);

endmodule // gpio_ports_b_c_d
`default_nettype wire

// ### gpio_pin_world.sv
// Pad model for the three ports: resolves every pad from the block and the outside world.
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_world (
   // Clock
   input wire logic clk_sys,
   // Block drivers
   input wire gpio_pkg::pin8_t analog_pin,
   input wire logic [5:0] clock_pin_out,
   input wire logic [5:0] clock_pin_oe,
   input wire gpio_pkg::pin8_t pullup_pin,
   input wire logic [7:0] pullup_on,
   // Outside drivers; a set float bit leaves that pad undriven
   input wire logic [7:0] analog_drive,
   input wire logic [5:0] clock_drive,
   input wire logic [7:0] pullup_drive,
   input wire logic [7:0] pullup_float,
   // Pad levels seen by the block
   output logic [7:0] analog_pin_in,
   output logic [5:0] clock_pin_in,
   output logic [7:0] pullup_pin_in
);
   logic alt_ff = 1'h0;

   // A bare floating pad toggles, so a missing pullup never reads as a lucky constant.
   always @(posedge clk_sys) begin
      alt_ff <= ~alt_ff;
   end

   // An enabled driver wins; otherwise the outside level reaches the pad.
   assign analog_pin_in = (analog_pin.oe & analog_pin.out) | (~analog_pin.oe & analog_drive);
   assign clock_pin_in = (clock_pin_oe & clock_pin_out) | (~clock_pin_oe & clock_drive);
   // A floating input pad is held high only where its pullup is switched on.
   assign pullup_pin_in = (pullup_pin.oe & pullup_pin.out)
      | (~pullup_pin.oe & ~pullup_float & pullup_drive)
      | (~pullup_pin.oe & pullup_float & (pullup_on | {8{alt_ff}}));
endmodule // gpio_pin_world
`default_nettype wire

// ### test_gpio_ports_b_c_d.sv
// Self-checking bench for the three-port I/O block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_gpio_ports_b_c_d;
   typedef struct packed {logic wr; logic [5:0] idx; logic [7:0] val;} row_t;
   logic clk_sys, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00, pullup_float = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [4:0] conv_channel_select = 5'h1F;
   logic [2:0] timer_a_prescaler_select = 3'h0, timer_b_prescaler_select = 3'h0;
   logic pready, pslverr, err, timer_a_ext_clock, timer_b_ext_clock;
   logic [7:0] analog_pin_in, converter_input_pins, pullup_pin_in, pullup_on, strong_sink_on;
   logic [5:0] clock_pin_in, clock_pin_out, clock_pin_oe;
   gpio_pkg::pin8_t analog_pin, pullup_pin;
   int failures = 0, n_compared = 0, cycles = 0;
   // Latches are loaded before their direction bits are set.
   row_t rows [14] = '{'{1'h1, 6'h01, 8'h3C}, '{1'h0, 6'h01, 8'h5A}, '{1'h1, 6'h05, 8'hF0},
      '{1'h0, 6'h01, 8'h3A}, '{1'h0, 6'h05, 8'hF0}, '{1'h1, 6'h02, 8'h15}, '{1'h1, 6'h06, 8'h07},
      '{1'h0, 6'h02, 8'h2D}, '{1'h0, 6'h06, 8'h07}, '{1'h1, 6'h03, 8'hA5}, '{1'h1, 6'h07, 8'h0F},
      '{1'h0, 6'h03, 8'hD5}, '{1'h0, 6'h07, 8'h0F}, '{1'h0, 6'h0E, 8'h00}};

   gpio_ports_b_c_d DUT (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .analog_pin_in, .analog_pin, .conv_channel_select,
      .converter_input_pins, .clock_pin_in, .clock_pin_out, .clock_pin_oe, .pullup_pin_in,
      .pullup_pin, .pullup_on, .strong_sink_on, .timer_a_prescaler_select,
      .timer_b_prescaler_select, .timer_a_ext_clock, .timer_b_ext_clock);
   gpio_pin_world pads (.clk_sys, .analog_pin, .clock_pin_out, .clock_pin_oe, .pullup_pin,
      .pullup_on, .analog_drive(8'h5A), .clock_drive(6'h2E), .pullup_drive(8'hD3),
      .pullup_float, .analog_pin_in, .clock_pin_in, .pullup_pin_in);

   // Prints the verdict and ends the run.
   task automatic results();
      if (failures == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One APB transfer; the request is held until pready is seen high at an edge.
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
      @(posedge clk_sys);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clk_sys);
      penable <= 1'h1;
      do @(posedge clk_sys); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // Lets the edge's register updates land before outputs are looked at.
   task automatic settle();
      @(posedge clk_sys);
      #1;
   endtask

   // Clock generation.
   initial begin
      clk_sys = 1'h0;
      forever #4 clk_sys = ~clk_sys;
   end

   // A hung handshake would stall forever, so the cycle count is capped.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         failures++;
         results();
      end
   end

   // Main sequence: table rows first, then the awkward cases.
   initial begin
      repeat (3) @(posedge clk_sys);
      nrst <= 1'h1;
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].idx, rows[i].val);
         if (rows[i].wr === 1'h0) `CHK("data read", {24'h0, rows[i].val}, rd)
      end
      conv_channel_select <= 5'h05;
      settle();
      `CHK("clock oe", 6'h07, clock_pin_oe)
      `CHK("analog out", 8'h3C, analog_pin.out)
      `CHK("selected oe", 8'hD0, analog_pin.oe)
      `CHK("converter pins", 8'h20, converter_input_pins)
      apb(1'h0, gpio_pkg::IDX_ANALOG_DATA, 8'h00);
      `CHK("selected read", 32'h1A, rd)
      conv_channel_select <= 5'h08;
      settle();
      `CHK("no channel", 8'h00, converter_input_pins)
      `CHK("analog oe", 8'hF0, analog_pin.oe)
      apb(1'h1, gpio_pkg::IDX_PULLUP_EN, 8'hFF);
      pullup_float <= 8'h20;
      settle();
      `CHK("pullup on", 8'hF0, pullup_on)
      `CHK("strong sink", 8'h0F, strong_sink_on)
      apb(1'h0, gpio_pkg::IDX_PULLUP_DATA, 8'h00);
      `CHK("pulled read", 32'hF5, rd)
      timer_a_prescaler_select <= gpio_pkg::PS_EXT_CLK;
      timer_b_prescaler_select <= gpio_pkg::PS_EXT_CLK;
      settle();
      `CHK("timer a clock", 1'h1, timer_a_ext_clock)
      `CHK("timer b clock", 1'h1, timer_b_ext_clock)
      apb(1'h0, 6'h3F, 8'h00);
      `CHK("unmapped read", 32'h0, rd)
      `CHK("unmapped error", 1'h1, err)
      timer_a_prescaler_select <= 3'h6;
      timer_b_prescaler_select <= 3'h3;
      settle();
      `CHK("timer a off", 1'h0, timer_a_ext_clock)
      `CHK("timer b off", 1'h0, timer_b_ext_clock)
      apb(1'h1, gpio_pkg::IDX_CLOCK_DIR, 8'h80);
      settle();
      `CHK("clock out oe", 6'h04, clock_pin_oe)
      `CHK("clock high", 1'h1, clock_pin_out[2])
      #4;
      `CHK("clock low", 1'h0, clock_pin_out[2])
      apb(1'h0, gpio_pkg::IDX_CLOCK_DATA, 8'h00);
      `CHK("clock data read", 32'h2A, rd)
      apb(1'h1, gpio_pkg::IDX_CLOCK_DIR, 8'h00);
      settle();
      `CHK("clock released oe", 6'h00, clock_pin_oe)
      `CHK("clock released out", 6'h15, clock_pin_out)
      @(posedge clk_sys);
      nrst <= 1'h0;
      settle();
      `CHK("reset analog oe", 8'h00, analog_pin.oe)
      `CHK("reset clock oe", 6'h00, clock_pin_oe)
      `CHK("reset pullup on", 8'h00, pullup_on)
      `CHK("kept analog latch", 8'h3C, analog_pin.out)
      `CHK("kept clock latch", 6'h15, clock_pin_out)
      `CHK("kept pullup latch", 8'hA5, pullup_pin.out)
      @(posedge clk_sys);
      nrst <= 1'h1;
      apb(1'h0, gpio_pkg::IDX_CLOCK_DIR, 8'h00);
      `CHK("reset clock dir", 32'h0, rd)
      results();
   end
endmodule // test_gpio_ports_b_c_d
`default_nettype wire
